// *** flash_array_model.sv ***
// Purpose: Behavioural flash array and non-volatile lock word behind the command unit
// Assumes: 128 modelled words, index taken from sector bits and the low address nibble
// Notes: erase_good low makes every erase pulse fail verify, so the retry limit can be reached
`timescale 1ns/1ns
`default_nettype none
module flash_array_model #(
  parameter logic [15:0] INIT_LOCK = 16'h7ffe
) (
  input wire logic mclk,
  input wire logic [15:0] bus_addr,
  input wire logic [1:0] arr_op,
  input wire logic [15:0] arr_addr,
  input wire logic [15:0] arr_wdata,
  input wire logic [7:0] arr_sectors,
  input wire logic lock_wr,
  input wire logic [15:0] lock_wr_data,
  input wire logic erase_good,
  output logic [15:0] arr_rdata,
  output logic arr_erased,
  output logic [15:0] nv_lock_word
);
  logic [15:0] mem [0:127];
  logic pulsed;
  function automatic logic [6:0] idx(logic [15:0] a);
    return {a[15:13], a[3:0]};
  endfunction
  assign arr_rdata = mem[idx(bus_addr)];
  assign arr_erased = erase_good && pulsed;
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 16'hffff;
    nv_lock_word = INIT_LOCK;
    pulsed = 1'b0;
  end
  always @(posedge mclk)
  begin
    // Lock cells only ever clear; a cleared lock bit never comes back
    if (lock_wr)
      nv_lock_word <= nv_lock_word & lock_wr_data;
    if (arr_op == 2'h3)
      pulsed <= 1'b1;
    else if (arr_op == 2'h2)
      pulsed <= 1'b0;
    if (arr_op == 2'h1)
      mem[idx(arr_addr)] <= mem[idx(arr_addr)] & arr_wdata;
    for (int i = 0; i < 128; i++)
      if (arr_sectors[i / 16])
      begin
        if (arr_op == 2'h2)
          mem[i] <= 16'h0000;
        if (arr_op == 2'h3 && erase_good)
          mem[i] <= 16'hffff;
      end
  end
endmodule
`default_nettype wire

// *** flash_cmd_pkg.sv ***
// Purpose: Shared constants and state type for the flash command and protection unit
// Assumes: 50 MHz mclk, 16-bit word bus from the CPU
// Notes: Timing figures kept in their own units, cycle counts derived from them
package flash_cmd_pkg;
  localparam int CLK_NS = 20;
  localparam int WINDOW_NS = 96000;
  localparam int WINDOW_CYCLES = WINDOW_NS / CLK_NS;
  localparam int SUSP_MIN_NS = 100;
  localparam int SUSP_MAX_NS = 15000;
  localparam int SUSP_CYCLES = (SUSP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUSP_MAX_CYCLES = SUSP_MAX_NS / CLK_NS;
  localparam int PROG_CYCLES = 500;
  localparam int PREPROG_CYCLES = 1000;
  localparam int ERASE_PULSE_CYCLES = 1000;
  localparam int MAX_PULSES = 16;
  localparam logic [13:0] ADDR_UNLOCK_A = 14'h1554;
  localparam logic [13:0] ADDR_UNLOCK_B = 14'h2aa8;
  localparam logic [7:0] DATA_UNLOCK_A = 8'ha8;
  localparam logic [7:0] DATA_UNLOCK_B = 8'h54;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_EN = 8'h80;
  localparam logic [7:0] CMD_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_PROTECT = 8'hc0;
  localparam logic [15:0] CODE_LOCK_WORD = 16'h009b;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_A_BIT = 6;
  localparam int FAIL_BIT = 5;
  localparam int WINDOW_BIT = 3;
  localparam int TOGGLE_B_BIT = 2;
  localparam int CODE_LOCK_BIT = 15;
  localparam int NUM_LOCKED_SECTORS = 7;
  localparam logic [15:0] LOCK_USED_MASK = 16'h807f;
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_PREPROGRAM = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  typedef enum logic [3:0] {
    ST_READ = 4'h0, ST_UNLOCK1 = 4'h1, ST_UNLOCK2 = 4'h2, ST_PROG_DATA = 4'h3,
    ST_ERASE_EN = 4'h4, ST_ERASE_U1 = 4'h5, ST_ERASE_U2 = 4'h6, ST_WINDOW = 4'h7,
    ST_ERASE = 4'h8, ST_SUSP_WAIT = 4'h9, ST_SUSP = 4'ha, ST_PROG = 4'hb,
    ST_PROT_DATA = 4'hc, ST_SUSP_U1 = 4'hd, ST_SUSP_U2 = 4'he, ST_SUSP_PDATA = 4'hf
  } state_t;
endpackage

// *** flash_command_protection_unit.sv ***
// Purpose: Command decoder, program/erase sequencer and lock word handling for on-chip flash
// Assumes: One CPU access per cycle; arr_rdata is the array word at bus_addr in the same cycle
// Notes: Array macro timing is modelled by cycle counters; arr_erased reports verify result
// Notes on behaviour
// R1 - Outside-flash reads return 009Bh while code lock bit is zero
// R2 - Locked sectors are never programmed or erased unless temporarily unlocked
// R3 - Write after protect cycles programs lock word; bits only clear, never set
// R4 - Data F0h, optionally after unlock pair, returns to array reads
// R5 - Host waits 10 us after read/reset that ended program or erase
// R6 - Program word: unlock pair, A0h at 1554h, then address and data latched
// R7 - Program that would raise a stored zero to one flags fail
// R8 - Poll, toggle A and fail flag report programming progress; toggle B does not move while programming, only toggle A
// R9 - Sector erase: unlock, 80h at 1554h, unlock, 30h at sector address
// R10 - Each extra 30h confirm adds a sector and restarts the window
// R11 - Erase window flag reads zero during window, one while erasing
// R12 - Wrong unlock cycle or non-confirm second command returns to read
// R13 - Controller preprograms target to zero before erasing to all ones
// R14 - Once erase starts, reads return status instead of array data
// R15 - While erasing only suspend and read/reset are accepted
// R16 - Poll reads zero then one; toggles alternate per read during erase
// R17 - Erase failing after maximum pulses sets fail; read/reset clears it
// R18 - Chip erase: six writes ending 10h; sequence error returns to read
// R19 - B0h to any address suspends, also ending a running window
// R20 - Suspend takes effect 0.1 to 15 us later; suspended sector reads toggle
// R21 - Suspended: only resume and program elsewhere; read/reset aborts erase
// R22 - 30h to any address while suspended resumes the erase
// R23 - New lock word takes effect only after the next reset
`timescale 1ns/1ns
`default_nettype none
module flash_command_protection_unit #(
  parameter int AW = 16,
  parameter int WINDOW_CYCLES = flash_cmd_pkg::WINDOW_CYCLES,
  parameter int PROG_CYCLES = flash_cmd_pkg::PROG_CYCLES,
  parameter int PREPROG_CYCLES = flash_cmd_pkg::PREPROG_CYCLES,
  parameter int ERASE_PULSE_CYCLES = flash_cmd_pkg::ERASE_PULSE_CYCLES,
  parameter int MAX_PULSES = flash_cmd_pkg::MAX_PULSES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_outside,
  input wire logic [AW-1:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic [15:0] arr_rdata,
  input wire logic arr_erased,
  input wire logic [15:0] nv_lock_word,
  input wire logic temp_sector_unlock,
  input wire logic temp_code_unlock,
  output logic [1:0] arr_op,
  output logic [AW-1:0] arr_addr,
  output logic [15:0] arr_wdata,
  output logic [7:0] arr_sectors,
  output logic lock_wr,
  output logic [15:0] lock_wr_data
);
  localparam int CW = 16;
  localparam int PW = 5;
  localparam logic [CW-1:0] SUSP_LAST = CW'(flash_cmd_pkg::SUSP_CYCLES - 1);

  flash_cmd_pkg::state_t state, next_state;
  logic [15:0] active_lock;
  logic [CW-1:0] cnt;
  logic [PW-1:0] pulses;
  logic preprog_done;
  logic from_susp;
  logic [2:0] susp_sector;
  logic fail_flag, toggle_flag_a, toggle_flag_b;

  // Command decode
  wire [7:0] wd = bus_wdata[7:0];
  wire [13:0] wa = bus_addr[13:0];
  wire [2:0] sector = bus_addr[AW-1 -: 3];
  wire is_reset = bus_wr && wd == flash_cmd_pkg::CMD_RESET;
  wire is_unl_a = bus_wr && wd == flash_cmd_pkg::DATA_UNLOCK_A && wa == flash_cmd_pkg::ADDR_UNLOCK_A;
  wire is_unl_b = bus_wr && wd == flash_cmd_pkg::DATA_UNLOCK_B && wa == flash_cmd_pkg::ADDR_UNLOCK_B;
  wire at_a = wa == flash_cmd_pkg::ADDR_UNLOCK_A;
  wire is_confirm = bus_wr && wd == flash_cmd_pkg::CMD_CONFIRM;
  wire is_suspend = bus_wr && wd == flash_cmd_pkg::CMD_SUSPEND;
  wire is_chip = bus_wr && wd == flash_cmd_pkg::CMD_CHIP;
  // Sector 7 has no lock bit and is always writable
  wire [7:0] unlocked = {1'b1, active_lock[6:0]} | {8{temp_sector_unlock}};
  wire sector_ok = unlocked[sector];
  wire raises_bit = |(bus_wdata & ~arr_rdata);
  wire code_locked = !active_lock[flash_cmd_pkg::CODE_LOCK_BIT] && !temp_code_unlock;
  wire cnt_end = (state == flash_cmd_pkg::ST_PROG) ? (cnt == CW'(PROG_CYCLES - 1)) :
                 (state == flash_cmd_pkg::ST_WINDOW) ? (cnt == CW'(WINDOW_CYCLES - 1)) :
                 (state == flash_cmd_pkg::ST_SUSP_WAIT) ? (cnt == SUSP_LAST) :
                 preprog_done ? (cnt == CW'(ERASE_PULSE_CYCLES - 1)) : (cnt == CW'(PREPROG_CYCLES - 1));
  wire erasing = state == flash_cmd_pkg::ST_ERASE;
  wire busy = erasing || state == flash_cmd_pkg::ST_PROG || state == flash_cmd_pkg::ST_WINDOW ||
              state == flash_cmd_pkg::ST_SUSP_WAIT;
  wire susp_read = (state == flash_cmd_pkg::ST_SUSP || state == flash_cmd_pkg::ST_SUSP_U1 ||
                    state == flash_cmd_pkg::ST_SUSP_U2) && sector == susp_sector;
  wire show_status = busy || fail_flag || susp_read; // see R14
  wire erase_done = erasing && cnt_end && preprog_done && arr_erased;
  wire erase_fail = erasing && cnt_end && preprog_done && !arr_erased && pulses == PW'(MAX_PULSES - 1);
  wire prog_bad = state inside {flash_cmd_pkg::ST_PROG_DATA, flash_cmd_pkg::ST_SUSP_PDATA} &&
                  bus_wr && (!sector_ok || (state == flash_cmd_pkg::ST_SUSP_PDATA && sector == susp_sector));
  wire prog_go = state inside {flash_cmd_pkg::ST_PROG_DATA, flash_cmd_pkg::ST_SUSP_PDATA} && bus_wr && !prog_bad;
  wire add_sector = (state == flash_cmd_pkg::ST_ERASE_U2 || state == flash_cmd_pkg::ST_WINDOW) &&
                    is_confirm && sector_ok;
  wire chip_go = state == flash_cmd_pkg::ST_ERASE_U2 && is_chip;
  wire [15:0] status_word = {8'h00, busy ? 1'b0 : 1'b1, toggle_flag_a, fail_flag, 1'b0,
                             state != flash_cmd_pkg::ST_WINDOW, toggle_flag_b, 2'b00}; // see R8 R11 R16

  always_comb
  begin
    next_state = state;
    case (state)
      flash_cmd_pkg::ST_READ:
        if (is_unl_a) next_state = flash_cmd_pkg::ST_UNLOCK1;
      flash_cmd_pkg::ST_UNLOCK1: // see R12
        next_state = is_unl_b ? flash_cmd_pkg::ST_UNLOCK2 : (bus_wr ? flash_cmd_pkg::ST_READ : state);
      flash_cmd_pkg::ST_UNLOCK2:
        if (bus_wr)
        begin
          if (at_a && wd == flash_cmd_pkg::CMD_PROGRAM) next_state = flash_cmd_pkg::ST_PROG_DATA; // see R6
          else if (at_a && wd == flash_cmd_pkg::CMD_ERASE_EN) next_state = flash_cmd_pkg::ST_ERASE_EN; // see R9
          else if (at_a && wd == flash_cmd_pkg::CMD_PROTECT) next_state = flash_cmd_pkg::ST_PROT_DATA;
          else next_state = flash_cmd_pkg::ST_READ; // see R4 R12
        end
      flash_cmd_pkg::ST_ERASE_EN:
        next_state = is_unl_a ? flash_cmd_pkg::ST_ERASE_U1 : (bus_wr ? flash_cmd_pkg::ST_READ : state);
      flash_cmd_pkg::ST_ERASE_U1:
        next_state = is_unl_b ? flash_cmd_pkg::ST_ERASE_U2 : (bus_wr ? flash_cmd_pkg::ST_READ : state);
      flash_cmd_pkg::ST_ERASE_U2: // see R9 R18
        if (add_sector) next_state = flash_cmd_pkg::ST_WINDOW;
        else if (chip_go) next_state = flash_cmd_pkg::ST_ERASE;
        else if (bus_wr) next_state = flash_cmd_pkg::ST_READ;
      flash_cmd_pkg::ST_WINDOW: // see R10 R19
        if (is_suspend) next_state = flash_cmd_pkg::ST_SUSP_WAIT;
        else if (bus_wr && !is_confirm) next_state = flash_cmd_pkg::ST_READ;
        else if (cnt_end && !is_confirm) next_state = flash_cmd_pkg::ST_ERASE;
      flash_cmd_pkg::ST_ERASE: // see R15 R17
        if (is_reset || erase_done || erase_fail) next_state = flash_cmd_pkg::ST_READ;
        else if (is_suspend) next_state = flash_cmd_pkg::ST_SUSP_WAIT;
      flash_cmd_pkg::ST_SUSP_WAIT: // see R20
        if (cnt_end) next_state = flash_cmd_pkg::ST_SUSP;
      flash_cmd_pkg::ST_SUSP: // see R21 R22
        if (is_confirm) next_state = flash_cmd_pkg::ST_ERASE;
        else if (is_unl_a) next_state = flash_cmd_pkg::ST_SUSP_U1;
        else if (is_reset) next_state = flash_cmd_pkg::ST_READ;
      flash_cmd_pkg::ST_SUSP_U1:
        next_state = is_unl_b ? flash_cmd_pkg::ST_SUSP_U2 : (bus_wr ? flash_cmd_pkg::ST_SUSP : state);
      flash_cmd_pkg::ST_SUSP_U2:
        if (bus_wr)
          next_state = (at_a && wd == flash_cmd_pkg::CMD_PROGRAM) ? flash_cmd_pkg::ST_SUSP_PDATA : flash_cmd_pkg::ST_SUSP;
      flash_cmd_pkg::ST_PROG_DATA, flash_cmd_pkg::ST_SUSP_PDATA:
        if (prog_go) next_state = flash_cmd_pkg::ST_PROG;
        else if (bus_wr) next_state = from_susp ? flash_cmd_pkg::ST_SUSP : flash_cmd_pkg::ST_READ; // see R2
      flash_cmd_pkg::ST_PROG:
        if (cnt_end || (is_reset && !from_susp)) next_state = from_susp ? flash_cmd_pkg::ST_SUSP : flash_cmd_pkg::ST_READ;
      flash_cmd_pkg::ST_PROT_DATA:
        if (bus_wr) next_state = flash_cmd_pkg::ST_READ;
      default:
        next_state = flash_cmd_pkg::ST_READ;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state <= flash_cmd_pkg::ST_READ;
      cnt <= '0;
      active_lock <= nv_lock_word; // see R23
    end
    else
    begin
      state <= next_state;
      cnt <= (next_state != state || add_sector || cnt_end) ? '0 : cnt + CW'(1);
    end
  end

  // Preprogram pass, then erase pulses each followed by a verify
  always_ff @(posedge mclk)
  begin
    if (!rstn || state == flash_cmd_pkg::ST_READ)
    begin
      preprog_done <= 1'b0;
      pulses <= '0;
    end
    else if (erasing && cnt_end)
    begin
      preprog_done <= 1'b1; // see R13
      if (preprog_done) pulses <= pulses + PW'(1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      from_susp <= 1'b0;
      susp_sector <= '0;
      arr_sectors <= '0;
    end
    else
    begin
      if (state == flash_cmd_pkg::ST_SUSP_U2 && bus_wr) from_susp <= 1'b1;
      else if (state == flash_cmd_pkg::ST_READ || state == flash_cmd_pkg::ST_ERASE) from_susp <= 1'b0;
      if (add_sector)
      begin
        arr_sectors <= (state == flash_cmd_pkg::ST_ERASE_U2 ? 8'h00 : arr_sectors) | (8'h01 << sector); // see R2 R10
        susp_sector <= sector;
      end
      else if (chip_go) arr_sectors <= unlocked; // see R2 R18
      else if (state == flash_cmd_pkg::ST_READ) arr_sectors <= '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      arr_op <= flash_cmd_pkg::OP_NONE;
      arr_addr <= '0;
      arr_wdata <= '0;
    end
    else
    begin
      if (prog_go)
      begin
        arr_addr <= bus_addr;
        arr_wdata <= bus_wdata;
      end
      // A word that would raise a bit is never handed to the array, only flagged
      if (prog_go) arr_op <= raises_bit ? flash_cmd_pkg::OP_NONE : flash_cmd_pkg::OP_PROGRAM; // see R7
      else if (next_state == flash_cmd_pkg::ST_ERASE && arr_sectors != 8'h00)
        arr_op <= (preprog_done || (erasing && cnt_end)) ? flash_cmd_pkg::OP_ERASE : flash_cmd_pkg::OP_PREPROGRAM;
      else if (next_state != flash_cmd_pkg::ST_PROG) arr_op <= flash_cmd_pkg::OP_NONE;
    end
  end

  // Status flags; read/reset clears fail, but a fail raised in the same cycle wins
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      fail_flag <= 1'b0;
      toggle_flag_a <= 1'b0;
      toggle_flag_b <= 1'b0;
    end
    else
    begin
      if (erase_fail || (prog_go && raises_bit)) fail_flag <= 1'b1; // see R7 R17
      else if (is_reset) fail_flag <= 1'b0;
      if (bus_rd && !bus_outside && show_status)
      begin
        if (!susp_read && busy) toggle_flag_a <= !toggle_flag_a; // see R16
        if (erasing || state == flash_cmd_pkg::ST_WINDOW || susp_read) toggle_flag_b <= !toggle_flag_b; // see R20
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      bus_rdata <= '0;
      bus_rvalid <= 1'b0;
      lock_wr <= 1'b0;
      lock_wr_data <= 16'hffff;
    end
    else
    begin
      bus_rvalid <= bus_rd;
      if (bus_rd)
        bus_rdata <= (bus_outside && code_locked) ? flash_cmd_pkg::CODE_LOCK_WORD : // see R1
                     show_status ? status_word : arr_rdata;
      lock_wr <= state == flash_cmd_pkg::ST_PROT_DATA && bus_wr;
      if (state == flash_cmd_pkg::ST_PROT_DATA && bus_wr)
        lock_wr_data <= nv_lock_word & (bus_wdata | ~flash_cmd_pkg::LOCK_USED_MASK); // see R3
    end
  end

  // Suspend lands after the wait count plus the cycle that enters the wait
  localparam int SUSP_LO = flash_cmd_pkg::SUSP_CYCLES;
  localparam int SUSP_HI = flash_cmd_pkg::SUSP_CYCLES + 1;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_suspend_cmd;
    (state == flash_cmd_pkg::ST_WINDOW || (erasing && !erase_done && !erase_fail)) && is_suspend;
  endsequence
  sequence s_suspended;
    state == flash_cmd_pkg::ST_SUSP;
  endsequence
  a_code_lock_read: assert property (bus_rd && bus_outside && code_locked |=> bus_rdata == 16'h009b) // see R1
    else $error("outside read of locked code not replaced");
  a_locked_no_prog: assert property (prog_bad |=> arr_op != flash_cmd_pkg::OP_PROGRAM) // see R2
    else $error("locked sector was programmed");
  a_lock_only_clears: assert property (lock_wr |-> (lock_wr_data & ~$past(nv_lock_word)) == 16'h0000) // see R3
    else $error("lock word bit raised");
  a_reset_to_read: assert property (state == flash_cmd_pkg::ST_UNLOCK2 && is_reset
    |=> state == flash_cmd_pkg::ST_READ) // see R4
    else $error("read/reset did not return to read mode");
  a_raise_sets_fail: assert property (prog_go && raises_bit |=> fail_flag) // see R7
    else $error("zero to one program not flagged");
  a_window_flag: assert property (state == flash_cmd_pkg::ST_WINDOW && bus_rd && !bus_outside
    |=> bus_rdata[flash_cmd_pkg::WINDOW_BIT] == 1'b0) // see R11
    else $error("window flag not zero during window");
  a_bad_unlock_abort: assert property (state == flash_cmd_pkg::ST_UNLOCK1 && bus_wr && !is_unl_b
    |=> state == flash_cmd_pkg::ST_READ) // see R12
    else $error("wrong unlock cycle not aborted");
  a_erase_ignores: assert property (erasing && bus_wr && !is_suspend && !is_reset && !cnt_end
    |=> erasing) // see R15
    else $error("command accepted during erase");
  a_suspend_delay: assert property (s_suspend_cmd |-> ##[SUSP_LO:SUSP_HI] s_suspended) // see R20
    else $error("suspend not effective in time");
  a_resume_erase: assert property (s_suspended ##0 is_confirm |=> erasing) // see R22
    else $error("resume did not restart erase");
  a_erase_status: assert property (erasing && bus_rd && !bus_outside
    |=> bus_rdata[flash_cmd_pkg::POLL_BIT] == 1'b0 && bus_rdata[15:8] == 8'h00) // see R14 R16
    else $error("erase read did not return status");
endmodule
`default_nettype wire

// *** test_flash_command_protection_unit.sv ***
// Purpose: Self-checking bench for the flash command and protection unit
// Assumes: Short timing parameters; array starts erased, code and sector 0 locked
// Notes: Reads note their expectation in a queue; a monitor compares on bus_rvalid
`timescale 1ns/1ns
`default_nettype none
module test_flash_command_protection_unit;
  logic mclk = 1'b0, rstn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, bus_outside = 1'b0;
  logic temp_sector_unlock = 1'b0, temp_code_unlock = 1'b0, erase_good = 1'b1;
  logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000, prev_rd = 16'h0000, d;
  logic [15:0] bus_rdata, arr_rdata, nv_lock_word, arr_addr, arr_wdata, lock_wr_data;
  logic bus_rvalid, arr_erased, lock_wr;
  logic [1:0] arr_op;
  logic [7:0] arr_sectors;
  int fails = 0, n_compared = 0;
  typedef struct {logic [15:0] exp; logic [15:0] mask; bit tog;} note_t;
  note_t notes[$];
  note_t n;
  flash_command_protection_unit #(.WINDOW_CYCLES(8), .PROG_CYCLES(4), .PREPROG_CYCLES(4),
    .ERASE_PULSE_CYCLES(4), .MAX_PULSES(2)) dut_u (.mclk(mclk), .rstn(rstn), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_outside(bus_outside), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .arr_rdata(arr_rdata), .arr_erased(arr_erased),
    .nv_lock_word(nv_lock_word), .temp_sector_unlock(temp_sector_unlock),
    .temp_code_unlock(temp_code_unlock), .arr_op(arr_op), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_sectors(arr_sectors), .lock_wr(lock_wr), .lock_wr_data(lock_wr_data));
  flash_array_model array_u (.mclk(mclk), .bus_addr(bus_addr), .arr_op(arr_op),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_sectors(arr_sectors), .lock_wr(lock_wr),
    .lock_wr_data(lock_wr_data), .erase_good(erase_good), .arr_rdata(arr_rdata),
    .arr_erased(arr_erased), .nv_lock_word(nv_lock_word));
  always #10 mclk = ~mclk;
  task automatic stop_test();
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp16(string what, logic [15:0] exp, logic [15:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask
  task automatic idle(int k);
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    cyc(k);
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] v);
    bus_addr = a;
    bus_wdata = v;
    bus_rd = 1'b0;
    bus_wr = 1'b1;
    cyc(1);
  endtask
  // Toggle notes expect the masked bits inverted against the previous answer
  task automatic rd(logic [15:0] a, logic [15:0] e, logic [15:0] m = 16'hffff, bit t = 0, bit o = 0);
    notes.push_back('{e, m, t});
    bus_addr = a;
    bus_outside = o;
    bus_wr = 1'b0;
    bus_rd = 1'b1;
    cyc(1);
  endtask
  task automatic cw(logic [7:0] v);
    wr({2'b00, flash_cmd_pkg::ADDR_UNLOCK_A}, {8'h00, v});
  endtask
  task automatic unl();
    cw(flash_cmd_pkg::DATA_UNLOCK_A);
    wr({2'b00, flash_cmd_pkg::ADDR_UNLOCK_B}, {8'h00, flash_cmd_pkg::DATA_UNLOCK_B});
  endtask
  task automatic prog(logic [15:0] a, logic [15:0] v);
    unl();
    cw(flash_cmd_pkg::CMD_PROGRAM);
    wr(a, v);
  endtask
  task automatic erase_start(logic [15:0] a);
    unl();
    cw(flash_cmd_pkg::CMD_ERASE_EN);
    unl();
    wr(a, 16'h0030);
  endtask
  task automatic wait_op(logic [1:0] op, int lim);
    int k = 0;
    // A read strobe left standing here would make reads with no note behind them
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    while (arr_op !== op && k < lim)
    begin
      cyc(1);
      k++;
    end
    cmp16("arr_op", {14'h0000, op}, {14'h0000, arr_op});
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    idle(16);
    rstn = 1'b1;
  endtask
  function automatic logic [15:0] sa(logic [2:0] s);
    return {s, 13'h0005};
  endfunction
  always @(negedge mclk)
    if (bus_rvalid === 1'b1)
    begin
      if (notes.size() == 0)
        cmp16("bus_rdata unexpected", 16'h0000, bus_rdata);
      else
      begin
        n = notes.pop_front();
        cmp16("bus_rdata", (n.tog ? ~prev_rd : n.exp) & n.mask, bus_rdata & n.mask);
      end
      prev_rd = bus_rdata;
    end
  // Longest path is three 10 us recovery waits plus a few hundred command cycles
  initial
  begin
    #400000;
    fails++;
    stop_test();
  end
  initial
  begin
    void'($urandom(32'hcc0b));
    d = 16'($urandom) & 16'hfffe;
    do_reset();
    rd(sa(1), 16'hffff);
    rd(sa(1), flash_cmd_pkg::CODE_LOCK_WORD, 16'hffff, 0, 1);
    temp_code_unlock = 1'b1;
    rd(sa(1), 16'hffff, 16'hffff, 0, 1);
    temp_code_unlock = 1'b0;
    prog(sa(1), d);
    cmp16("arr_addr", sa(1), arr_addr);
    cmp16("arr_wdata", d, arr_wdata);
    rd(sa(1), 16'h0000, 16'h00a0);
    rd(sa(1), 16'h0000, 16'h0040, 1);
    idle(8);
    rd(sa(1), d);
    prog(sa(1), d | 16'h0001);
    idle(8);
    rd(sa(1), 16'h00a0, 16'h00a0);
    unl();
    wr(sa(6), 16'h00f0);
    idle(500);
    rd(sa(1), d);
    prog(sa(0), 16'h1234);
    idle(8);
    rd(sa(0), 16'hffff);
    temp_sector_unlock = 1'b1;
    prog(sa(0), 16'h1234);
    idle(8);
    temp_sector_unlock = 1'b0;
    rd(sa(0), 16'h1234);
    wr(16'h1554, 16'h00a8);
    wr(16'h2aa8, 16'h0055);
    cw(flash_cmd_pkg::CMD_PROGRAM);
    wr(sa(2), 16'h0000);
    idle(8);
    rd(sa(2), 16'hffff);
    unl();
    cw(flash_cmd_pkg::CMD_ERASE_EN);
    unl();
    wr(sa(2), 16'h00a0);
    wr(sa(2), 16'h0030);
    idle(8);
    rd(sa(2), 16'hffff);
    erase_good = 1'b0;
    erase_start(sa(1));
    wr(sa(2), 16'h0030);
    rd(sa(1), 16'h0000, 16'h0088);
    wait_op(2'h2, 40);
    wait_op(2'h3, 20);
    rd(sa(1), 16'h0008, 16'h00a8);
    rd(sa(1), 16'h0000, 16'h0044, 1);
    prog(sa(3), 16'h0000);
    idle(16);
    rd(sa(1), 16'h0020, 16'h0020);
    wr(sa(6), 16'h00f0);
    idle(500);
    rd(sa(1), 16'h0000);
    rd(sa(3), 16'hffff);
    erase_good = 1'b1;
    unl();
    cw(flash_cmd_pkg::CMD_ERASE_EN);
    unl();
    cw(flash_cmd_pkg::CMD_CHIP);
    idle(1);
    cmp16("arr_sectors", 16'h00fe, {8'h00, arr_sectors});
    wait_op(2'h2, 40);
    wait_op(2'h0, 80);
    rd(sa(1), 16'hffff);
    rd(sa(0), 16'h1234);
    erase_start(sa(4));
    wr(sa(7), 16'h00b0);
    idle(6);
    rd(sa(5), 16'hffff);
    rd(sa(4), 16'h0000, 16'h0000);
    rd(sa(4), 16'h0000, 16'h0004, 1);
    rd(sa(4), 16'h0000, 16'h0004, 1);
    prog(sa(5), 16'h0f0f);
    idle(8);
    rd(sa(5), 16'h0f0f);
    wr(sa(6), 16'h0030);
    rd(sa(4), 16'h0000, 16'h0080);
    idle(80);
    rd(sa(4), 16'hffff);
    erase_start(sa(5));
    wr(sa(7), 16'h00b0);
    idle(6);
    wr(sa(7), 16'h00f0);
    idle(500);
    rd(sa(6), 16'hffff);
    unl();
    cw(flash_cmd_pkg::CMD_PROTECT);
    wr(sa(0), 16'hfffb);
    cmp16("lock_wr", 16'h0001, {15'h0000, lock_wr});
    cmp16("lock_wr_data", 16'h7ffa, lock_wr_data);
    prog(sa(2), 16'h00f0);
    idle(8);
    rd(sa(2), 16'h00f0);
    do_reset();
    prog(sa(2), 16'h0000);
    idle(8);
    rd(sa(2), 16'h00f0);
    idle(4);
    stop_test();
  end
endmodule
`default_nettype wire
